// >>> hss_pkg.sv
// constants shared by the strap sampling and status pin logic
package hss_pkg;

  // port count and strap field widths
  localparam int unsigned NUM_PORTS      = 4;
  localparam int unsigned CODE_W         = 2;
  localparam int unsigned CFG_W          = 2;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STRAP_OFS       = 8'h04;
  localparam logic [7:0] HUB_STAT_OFS    = 8'h08;
  localparam logic [7:0] ID_OFS          = 8'h0C;

  // control register fields and reset value
  localparam int unsigned CTRL_PIN_IN_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // strap status register fields
  localparam int unsigned ST_CODE_LSB    = 0;
  localparam int unsigned ST_CHG_LSB     = 4;
  localparam int unsigned ST_CFG_LSB     = 8;
  localparam int unsigned ST_EN_BIT      = 12;
  localparam int unsigned ST_DONE_BIT    = 13;
  localparam int unsigned ST_LOW_ACT_BIT = 14;
  localparam int unsigned ST_MASK_LSB    = 16;

  // hub status register fields
  localparam int unsigned HS_CONF_BIT    = 0;
  localparam int unsigned HS_SUSP_BIT    = 1;
  localparam int unsigned HS_LED_BIT     = 2;
  localparam int unsigned HS_LPWR_BIT    = 3;
  localparam int unsigned HS_CMPD_BIT    = 4;

  // block identity, value is arbitrary
  localparam logic [31:0] BLOCK_ID       = 32'h0000_5A01;

  // fixed port codes
  localparam logic [1:0] CODE_NONE       = 2'h0;
  localparam logic [1:0] CODE_P1         = 2'h1;
  localparam logic [1:0] CODE_P12        = 2'h2;
  localparam logic [1:0] CODE_P123       = 2'h3;

  // configuration select value that disables the straps
  localparam logic [1:0] CFG_SERIAL      = 2'h1;

  // values after reset of sampled straps
  localparam logic [1:0] CODE_RESET      = 2'h0;
  localparam logic [3:0] CHG_RESET       = 4'h0;
  localparam logic [1:0] CFG_RESET       = 2'h0;

endpackage

// >>> hss_led_if.sv
// signals between the strap core and the shared status pin driver
`timescale 1ns/1ps
`default_nettype none
interface hss_led_if;
  logic led_active;
  logic led_active_low;
  logic pin_as_input;
  logic drive_allowed;
  logic local_power;

  modport core (
    output led_active,
    output led_active_low,
    output pin_as_input,
    output drive_allowed,
    input  local_power
  );

  modport drv (
    input  led_active,
    input  led_active_low,
    input  pin_as_input,
    input  drive_allowed,
    output local_power
  );
endinterface
`default_nettype wire

// >>> hss_led_drive.sv
// shared status pin driver: led output or local power detect input
`timescale 1ns/1ps
`default_nettype none
module hss_led_drive (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // shared pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe,
  // core side
  hss_led_if.drv    ctl
);

  logic pin_o_reg;
  logic pin_o_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic lpwr_reg;
  logic lpwr_next;

  always_comb begin
    // polarity flips the level, active high codes drive 1 when lit
    pin_o_next  = ctl.led_active ^ ctl.led_active_low; // see R8
    // pin released during reset and sampling so the strap resistor sets it
    pin_oe_next = ctl.drive_allowed && !ctl.pin_as_input; // see R8
    // low means bus powered only, high means local supply present
    // wait until the driver is off, else the led level reads back as supply
    lpwr_next   = (ctl.pin_as_input && !pin_oe_reg) ? pin_i : lpwr_reg; // see R3, R4
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_reg  <= 1'b0;
      pin_oe_reg <= 1'b0;
      lpwr_reg   <= 1'b0;
    end else begin
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
      lpwr_reg   <= lpwr_next;
    end
  end

  assign pin_o           = pin_o_reg;
  assign pin_oe          = pin_oe_reg;
  assign ctl.local_power = lpwr_reg;

endmodule
`default_nettype wire

// >>> hss_strap_top.sv
// strap sampling, fixed port decode and status pin control with apb registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - led stays off while hub unconfigured, or configured but suspended
// R2 - led lit only while configured by host and not suspended
// R3 - local power detect low means hub is powered from upstream only
// R4 - local power detect high means a local self-power source exists
// R5 - with straps enabled, both fixed port bits sampled together at reset release
// R6 - code 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3 fixed
// R7 - led active high for codes 00 and 10, active low for 01 and 11
// R8 - shared strap pin becomes led output with polarity from its own strap
// R9 - strap pins ignored unless configuration selection enables straps
// R10 - pulled-down charge enable straps: high reads as 1, low as 0
// R11 - unstrapped bidirectional pins read 0 through the internal pull-down
// R12 - any fixed port makes the hub report itself as a compound device
// R13 - straps and configuration select latched at reset release
// R14 - sampled straps held constant until the next chip reset
module hss_strap_top (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // strap and configuration pins
  input  wire logic [hss_pkg::CFG_W-1:0]      cfg_sel,
  input  wire logic                           fixed_port_strap_hi,
  input  wire logic [hss_pkg::NUM_PORTS-1:0]  charge_enable_strap,
  // shared led / local power / strap pin
  input  wire logic                           status_pin_i,
  output logic                                status_pin_o,
  output logic                                status_pin_oe,
  // hub engine state
  input  wire logic                           hub_configured,
  input  wire logic                           hub_suspended,
  // decoded configuration to the hub engine
  output logic      [hss_pkg::NUM_PORTS-1:0]  fixed_port_mask,
  output logic      [hss_pkg::NUM_PORTS-1:0]  charge_enable,
  output logic                                compound_device,
  output logic                                local_power_detect,
  output logic                                suspend_status_led,
  output logic                                straps_valid
);

  // fixed port code to per-port mask
  function automatic logic [hss_pkg::NUM_PORTS-1:0] fixed_mask(
    input logic [hss_pkg::CODE_W-1:0] code
  );
    logic [hss_pkg::NUM_PORTS-1:0] m;
    m = '0;
    case (code)
      hss_pkg::CODE_NONE: m = 4'h0; // see R6
      hss_pkg::CODE_P1:   m = 4'h1; // see R6
      hss_pkg::CODE_P12:  m = 4'h3; // see R6
      hss_pkg::CODE_P123: m = 4'h7; // see R6
      default:            m = 4'h0;
    endcase
    return m;
  endfunction

  // odd codes light the led with a low level
  function automatic logic led_low_active(
    input logic [hss_pkg::CODE_W-1:0] code
  );
    return code[0]; // see R7
  endfunction

  // ---------------- strap capture ----------------
  logic                              sampled_reg;
  logic                              sampled_next;
  logic [hss_pkg::CODE_W-1:0]        code_reg;
  logic [hss_pkg::CODE_W-1:0]        code_next;
  logic [hss_pkg::NUM_PORTS-1:0]     chg_reg;
  logic [hss_pkg::NUM_PORTS-1:0]     chg_next;
  logic [hss_pkg::CFG_W-1:0]         cfg_reg;
  logic [hss_pkg::CFG_W-1:0]         cfg_next;
  logic                              str_en_reg;
  logic                              str_en_next;
  logic                              str_en_now;

  // serial configuration has its own settings, so straps count for nothing there
  assign str_en_now = (cfg_sel != hss_pkg::CFG_SERIAL); // see R9

  always_comb begin
    sampled_next = sampled_reg;
    code_next    = code_reg;
    chg_next     = chg_reg;
    cfg_next     = cfg_reg;
    str_en_next  = str_en_reg;
    // async reset cannot load pin levels, so capture on the first edge after release
    if (!sampled_reg) begin
      sampled_next = 1'b1; // see R13
      cfg_next     = cfg_sel; // see R13
      str_en_next  = str_en_now; // see R9
      if (str_en_now) begin
        // both bits taken in the same edge, pin driver still released
        code_next = {fixed_port_strap_hi, status_pin_i}; // see R5, R11
        chg_next  = charge_enable_strap; // see R10, R11
      end else begin
        code_next = hss_pkg::CODE_RESET; // see R9
        chg_next  = hss_pkg::CHG_RESET; // see R9
      end
    end
    // once sampled nothing above is reloaded until presetn falls again
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_reg <= 1'b0;
      code_reg    <= hss_pkg::CODE_RESET;
      chg_reg     <= hss_pkg::CHG_RESET;
      cfg_reg     <= hss_pkg::CFG_RESET;
      str_en_reg  <= 1'b0;
    end else begin
      sampled_reg <= sampled_next; // see R14
      code_reg    <= code_next; // see R14
      chg_reg     <= chg_next; // see R14
      cfg_reg     <= cfg_next; // see R14
      str_en_reg  <= str_en_next; // see R14
    end
  end

  // ---------------- decoded outputs ----------------
  logic [hss_pkg::NUM_PORTS-1:0]     mask_reg;
  logic [hss_pkg::NUM_PORTS-1:0]     mask_next;
  logic                              cmpd_reg;
  logic                              cmpd_next;
  logic                              led_reg;
  logic                              led_next;

  always_comb begin
    mask_next = fixed_mask(code_reg); // see R5, R6
    cmpd_next = |fixed_mask(code_reg); // see R12
    // lit only when configured and awake; unconfigured or suspended stays dark
    led_next  = sampled_reg && hub_configured && !hub_suspended; // see R1, R2
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
      cmpd_reg <= 1'b0;
      led_reg  <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      cmpd_reg <= cmpd_next;
      led_reg  <= led_next;
    end
  end

  // ---------------- control register ----------------
  logic                              pin_in_reg;
  logic                              pin_in_next;

  // ---------------- apb ----------------
  logic                              setup;
  logic                              access;
  logic                              hit_ctrl;
  logic                              hit_strap;
  logic                              hit_hub;
  logic                              hit_id;
  logic                              mapped;
  logic [31:0]                       rd_mux;
  logic [31:0]                       strap_word;
  logic [31:0]                       hub_word;
  logic [31:0]                       prdata_reg;
  logic [31:0]                       prdata_next;

  hss_led_if led_bus ();

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign hit_ctrl  = (paddr == hss_pkg::CTRL_OFS);
  assign hit_strap = (paddr == hss_pkg::STRAP_OFS);
  assign hit_hub   = (paddr == hss_pkg::HUB_STAT_OFS);
  assign hit_id    = (paddr == hss_pkg::ID_OFS);
  assign mapped    = hit_ctrl || hit_strap || hit_hub || hit_id;

  always_comb begin
    strap_word = '0;
    strap_word[hss_pkg::ST_CODE_LSB +: hss_pkg::CODE_W]   = code_reg;
    strap_word[hss_pkg::ST_CHG_LSB +: hss_pkg::NUM_PORTS] = chg_reg;
    strap_word[hss_pkg::ST_CFG_LSB +: hss_pkg::CFG_W]     = cfg_reg;
    strap_word[hss_pkg::ST_EN_BIT]                        = str_en_reg;
    strap_word[hss_pkg::ST_DONE_BIT]                      = sampled_reg;
    strap_word[hss_pkg::ST_LOW_ACT_BIT]                   = led_low_active(code_reg);
    strap_word[hss_pkg::ST_MASK_LSB +: hss_pkg::NUM_PORTS] = mask_reg;
  end

  always_comb begin
    hub_word = '0;
    hub_word[hss_pkg::HS_CONF_BIT] = hub_configured;
    hub_word[hss_pkg::HS_SUSP_BIT] = hub_suspended;
    hub_word[hss_pkg::HS_LED_BIT]  = led_reg;
    hub_word[hss_pkg::HS_LPWR_BIT] = led_bus.local_power;
    hub_word[hss_pkg::HS_CMPD_BIT] = cmpd_reg;
  end

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[hss_pkg::CTRL_PIN_IN_BIT] = pin_in_reg;
    end else if (hit_strap) begin
      rd_mux = strap_word;
    end else if (hit_hub) begin
      rd_mux = hub_word;
    end else if (hit_id) begin
      rd_mux = hss_pkg::BLOCK_ID;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    pin_in_next = pin_in_reg;
    // read data settles in the setup cycle so the access phase needs no wait
    if (setup && !pwrite) begin
      prdata_next = rd_mux;
    end
    if (access && pwrite && hit_ctrl) begin
      pin_in_next = pwdata[hss_pkg::CTRL_PIN_IN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pin_in_reg <= hss_pkg::CTRL_RESET[hss_pkg::CTRL_PIN_IN_BIT];
    end else begin
      prdata_reg <= prdata_next;
      pin_in_reg <= pin_in_next;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  // ---------------- shared pin ----------------
  assign led_bus.led_active     = led_reg;
  assign led_bus.led_active_low = led_low_active(code_reg); // see R7, R8
  assign led_bus.pin_as_input   = pin_in_reg;
  assign led_bus.drive_allowed  = sampled_reg; // see R8

  hss_led_drive u_led_drive (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_i   (status_pin_i),
    .pin_o   (status_pin_o),
    .pin_oe  (status_pin_oe),
    .ctl     (led_bus.drv)
  );

  // ---------------- outputs ----------------
  assign fixed_port_mask    = mask_reg;
  assign charge_enable      = chg_reg; // see R10
  assign compound_device    = cmpd_reg; // see R12
  assign local_power_detect = led_bus.local_power; // see R3, R4
  assign suspend_status_led = led_reg;
  assign straps_valid       = sampled_reg;

endmodule
`default_nettype wire

// >>> hss_board.sv
// board model: strap pulls, local supply and status led on the shared pin
`timescale 1ns/1ps
`default_nettype none
module hss_board (
  // from the block
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // board fitting
  input  wire logic strap_lo,
  input  wire logic supply_fit,
  input  wire logic supply_lvl,
  // to the block and to the eye
  output logic      pin_i,
  output logic      led_lit
);
  // released pin falls to the supply level if fitted, else the strap pull, never keeps the last driven value
  assign pin_i   = pin_oe ? pin_o : (supply_fit ? supply_lvl : strap_lo);
  // led wired to match its own strap, so lit level is the inverse of the pull
  assign led_lit = pin_oe & (pin_o ^ strap_lo);
endmodule
`default_nettype wire

// >>> hss_strap_top_monitor.sv
// port checker for the strap top
`timescale 1ns/1ps
`default_nettype none
module hss_strap_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // straps and pin
  input wire logic [1:0] cfg_sel,
  input wire logic       fixed_port_strap_hi,
  input wire logic [3:0] charge_enable_strap,
  input wire logic       status_pin_i,
  input wire logic       status_pin_o,
  input wire logic       status_pin_oe,
  // hub state and outputs
  input wire logic       hub_configured,
  input wire logic       hub_suspended,
  input wire logic [3:0] fixed_port_mask,
  input wire logic [3:0] charge_enable,
  input wire logic       compound_device,
  input wire logic       local_power_detect,
  input wire logic       suspend_status_led,
  input wire logic       straps_valid
);
  logic [1:0] code_reg;
  logic [3:0] chg_reg;
  logic       en_reg;
  logic [3:0] mask_exp;
  // own copy of the straps, taken while the block has not yet captured
  always_ff @(posedge pclk) begin
    if (!straps_valid) begin
      en_reg   <= (cfg_sel != 2'h1);
      code_reg <= {fixed_port_strap_hi, status_pin_i};
      chg_reg  <= charge_enable_strap;
    end
  end
  assign mask_exp = en_reg ? 4'((4'h1 << code_reg) - 4'h1) : 4'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_led_follows_hub: assert property (
    $past(straps_valid) |-> suspend_status_led == $past(hub_configured && !hub_suspended))
    else $error("led state wrong");
  a_pin_polarity: assert property (
    status_pin_oe && $past(straps_valid, 2) |->
    status_pin_o == ($past(suspend_status_led) ^ (en_reg & code_reg[0])))
    else $error("pin level wrong");
  a_mask_decode: assert property (
    $past(straps_valid) |-> fixed_port_mask == mask_exp)
    else $error("fixed mask wrong");
  a_compound_flag: assert property (
    straps_valid |-> compound_device == (fixed_port_mask != 4'h0))
    else $error("compound wrong");
  a_charge_sample: assert property (
    $past(straps_valid) |-> charge_enable == (en_reg ? chg_reg : 4'h0))
    else $error("charge enable wrong");
  a_straps_hold: assert property (
    straps_valid && $past(straps_valid, 2) |-> $stable(fixed_port_mask) && $stable(charge_enable))
    else $error("straps moved");
  a_capture_edge: assert property (
    $rose(presetn) || straps_valid |=> straps_valid)
    else $error("capture late");
  a_local_power: assert property (
    $changed(local_power_detect) |-> local_power_detect == $past(status_pin_i))
    else $error("local power wrong");
  a_apb_ready: assert property (
    psel && penable |-> pready)
    else $error("no ready");
  a_apb_unmapped: assert property (
    psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("no error");
  c_compound: cover property (straps_valid && compound_device);
  c_led_lit: cover property (status_pin_oe && suspend_status_led);
  c_refused: cover property (psel && penable && pslverr);
endmodule
bind hss_strap_top hss_strap_monitor mon (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .cfg_sel, .fixed_port_strap_hi, .charge_enable_strap, .status_pin_i, .status_pin_o,
  .status_pin_oe, .hub_configured, .hub_suspended, .fixed_port_mask, .charge_enable,
  .compound_device, .local_power_detect, .suspend_status_led, .straps_valid);
`default_nettype wire

// >>> tb_top.sv
// strap top bench: strap cases, led, local power and apb access
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [1:0] cfg_sel, cfg, code, ecode;
  logic [3:0] charge_enable_strap, fixed_port_mask, charge_enable, chg, echg, emask;
  logic fixed_port_strap_hi, status_pin_i, status_pin_o, status_pin_oe, err, en;
  logic hub_configured, hub_suspended, compound_device, local_power_detect;
  logic suspend_status_led, straps_valid, strap_lo, supply_fit, supply_lvl, led_lit;
  int fail_count, samples_checked;
  hss_strap_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_sel, .fixed_port_strap_hi, .charge_enable_strap, .status_pin_i,
    .status_pin_o, .status_pin_oe, .hub_configured, .hub_suspended, .fixed_port_mask,
    .charge_enable, .compound_device, .local_power_detect, .suspend_status_led,
    .straps_valid);
  hss_board brd (.pin_o(status_pin_o), .pin_oe(status_pin_oe), .strap_lo, .supply_fit,
    .supply_lvl, .pin_i(status_pin_i), .led_lit);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // waits on pready, giving up with a failure after 20 cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic boot;
    presetn <= 1'b0;
    supply_fit <= 1'b0;
    cfg_sel <= cfg;
    fixed_port_strap_hi <= code[1];
    strap_lo <= code[0];
    charge_enable_strap <= chg;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hub_configured, hub_suspended} = '0;
    {cfg_sel, fixed_port_strap_hi, charge_enable_strap, strap_lo, supply_fit} = '0;
    supply_lvl = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    for (int c = 0; c < 5; c++) begin
      // last pass uses the serial setup, which must ignore the straps
      cfg = (c == 4) ? hss_pkg::CFG_SERIAL : (c == 3) ? 2'h3 : {c[0], 1'b0};
      code = (c == 4) ? 2'h3 : c[1:0];
      chg = 4'(9 + c);
      boot();
      en = (cfg != hss_pkg::CFG_SERIAL);
      ecode = en ? code : 2'h0;
      echg = en ? chg : 4'h0;
      emask = 4'((4'h1 << ecode) - 4'h1);
      `CHK("mask", emask, fixed_port_mask)
      `CHK("compound", emask != 4'h0, compound_device)
      `CHK("charge", echg, charge_enable)
      apb(1'b0, hss_pkg::STRAP_OFS, 32'h0);
      `CHK("valid", 1'b1, straps_valid)
      ex = {12'h0, emask, 1'b0, ecode[0], 1'b1, en, 2'h0, cfg, echg, 2'h0, ecode};
      `CHK("strap reg", ex, rd)
      fixed_port_strap_hi <= ~code[1];
      charge_enable_strap <= ~chg;
      cfg_sel <= ~cfg;
      repeat (2) @(posedge pclk);
      `CHK("mask held", emask, fixed_port_mask)
      `CHK("charge held", echg, charge_enable)
      for (int k = 0; k < 4; k++) begin
        hub_configured <= k[0];
        hub_suspended <= k[1];
        repeat (3) @(posedge pclk);
        `CHK("led", k == 1, suspend_status_led)
        `CHK("pin", (k == 1) ^ ecode[0], status_pin_o)
        `CHK("oe", 1'b1, status_pin_oe)
        if (en) `CHK("lit", k == 1, led_lit)
      end
    end
    apb(1'b0, hss_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl reset", hss_pkg::CTRL_RESET, rd)
    apb(1'b1, hss_pkg::CTRL_OFS, 32'h1);
    supply_fit <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      supply_lvl <= v[0];
      repeat (3) @(posedge pclk);
      `CHK("local power", v[0], local_power_detect)
      `CHK("oe off", 1'b0, status_pin_oe)
    end
    apb(1'b0, hss_pkg::HUB_STAT_OFS, 32'h0);
    `CHK("hub lpwr", 1'b1, rd[hss_pkg::HS_LPWR_BIT])
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b0, hss_pkg::ID_OFS, 32'h0);
    `CHK("id", hss_pkg::BLOCK_ID, rd)
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
